// >>> hdl/rxs_pkg.sv
// Purpose: shared constants for the receiver serial control port
// Assumes: 32-bit words, bank 1 holds registers 0..3 and 5
// Notes: full register words keep their own address bits

package rxs_pkg;
    // ************************************************
    // word layout
    // ************************************************
    localparam int WORD_W = 32;
    localparam int SEL_LSB = 0;
    localparam int SEL_W = 3;
    localparam int BANK_LSB = 3;
    localparam int BANK_W = 2;
    localparam logic [1:0] BANK_SEL = 2'h1;
    localparam logic [2:0] REG_STATUS = 3'h0;
    localparam logic [2:0] REG_CTRL = 3'h1;
    localparam logic [2:0] REG_CAL = 3'h2;
    localparam logic [2:0] REG_LOAD = 3'h3;
    localparam logic [2:0] REG_TRIM = 3'h5;
    localparam int RB_SEL_LSB = 27;
    localparam logic [5:0] RB_BITS = 6'h20;

    // ************************************************
    // reset values
    // ************************************************
    localparam logic [31:0] CTRL_RST = 32'h0100_FC89;
    localparam logic [31:0] CAL_RST = 32'h71E0_200A;
    localparam logic [31:0] LOAD_RST = 32'h4000_000B;
    localparam logic [31:0] TRIM_RST = 32'h0000_AAAD;
    localparam logic [7:0] DAC_RST = 8'h80;

    // ************************************************
    // receiver control word fields
    // ************************************************
    localparam int C_MIX_OFF = 5;
    localparam int C_BUF_OFF = 7;
    localparam int C_FILT_OFF = 8;
    localparam int C_CALLOGIC_OFF = 10;
    localparam int C_GAIN_LSB = 12;
    localparam int GAIN_W = 5;
    localparam logic [4:0] GAIN_MAX = 5'h18;
    localparam int C_LPF_LSB = 17;
    localparam int C_DET_R = 25;
    localparam int C_DET_C = 26;
    localparam int C_FAST_EN = 27;
    localparam int C_FAST_X2 = 28;
    localparam int C_OSC_TEST = 29;
    localparam int C_ATTN = 31;

    // ************************************************
    // calibration control word fields
    // ************************************************
    localparam int K_START = 5;
    localparam int K_IDAC_LSB = 6;
    localparam int K_QDAC_LSB = 14;
    localparam int DAC_W = 8;
    localparam int K_IREF_LSB = 22;
    localparam int K_AUTO = 24;
    localparam int K_DIV_LSB = 25;
    localparam int K_CLKSEL = 28;
    localparam int K_OSC_LSB = 29;
    localparam logic [14:0] CAL_RATIO [8] = '{15'h0001, 15'h0008, 15'h0010,
        15'h0080, 15'h0100, 15'h0400, 15'h0800, 15'h412C};

    // mixer load / filter word
    localparam int L_BYPASS = 29;
    localparam int L_PEAK_LSB = 30;

    typedef enum logic [1:0] {
        DET_10MHZ = 2'h0,
        DET_10KHZ = 2'h1,
        DET_1KHZ = 2'h3
    } rxs_det_bw_e;

    // ************************************************
    // host controller registers (byte addresses)
    // ************************************************
    localparam logic [7:0] A_TX = 8'h00;
    localparam logic [7:0] A_CMD = 8'h04;
    localparam logic [7:0] A_STAT = 8'h08;
    localparam logic [7:0] A_RX = 8'h0C;
    localparam logic [7:0] A_DIV = 8'h10;
    localparam int CMD_WRITE = 0;
    localparam int CMD_READ = 1;
    localparam logic [7:0] DIV_RST = 8'h08;
endpackage

// >>> hdl/rxs_if.sv
// Purpose: three-wire serial port plus readback line
// Assumes: both ends run on their own pclk
// Notes: all wires single driver, no tri-state

interface rxs_if;
    logic sclk;
    logic sdata;
    logic load_strobe;
    logic readback;
    modport dev (input sclk, input sdata, input load_strobe, output readback);
    modport host (output sclk, output sdata, output load_strobe, input readback);
endinterface

// >>> hdl/rxs_dev.sv
// Purpose: receiver serial control port and register bank
// Assumes: link pins sampled by pclk, serial half period >= 7 pclk
// Notes: analog calibration replaced by a timed engine
//
// Overview of operation
// RULE_01 - 32-bit shift register receives every word
// RULE_02 - lsb first, sampled on serial clock rise
// RULE_03 - strobe rise copies word to target register
// RULE_04 - bits 0-2 register, 3-4 bank
// RULE_05 - readback command then read phase, includes DACs
// RULE_06 - drive bit each rise, host samples fall
// RULE_07 - one idle pulse, then 32 data pulses
// RULE_08 - register 1 power-down bits, one means off
// RULE_09 - five-bit baseband gain, 0..24, reset 15
// RULE_10 - eight-bit lowpass corner, reset 128
// RULE_11 - two detector bits select offset bandwidth
// RULE_12 - parallel gain enable and step doubler
// RULE_13 - bit 29 puts oscillator on readback
// RULE_14 - bit 31 attenuator, cleared at reset
// RULE_15 - start bit launches calibration, self-clears
// RULE_16 - manual I and Q codes, reset 128
// RULE_17 - reference current select, reset 11
// RULE_18 - calibration method bit, reset one
// RULE_19 - calibration clock divider ratio select
// RULE_20 - calibration clock source select, reset one
// RULE_21 - oscillator trim field
// RULE_22 - four six-bit mixer load fields, reset zero
// RULE_23 - filter bypass and peaking control
// RULE_24 - unmatched address strobes are ignored
//
// Design decisions made here: the APB register port and the register offsets.

module rxs_dev #(
    parameter int CAL_STEPS = 8,
    parameter logic [1:0] ID_CODE = 2'h2 // arbitrary value
) (
    input wire logic pclk,
    input wire logic presetn,
    rxs_if.dev link,
    input wire logic [2:0] gain_pins,
    input wire logic osc_level,
    input wire logic [7:0] cal_i_result,
    input wire logic [7:0] cal_q_result,
    output logic [31:0] ctrl_word,
    output logic [31:0] cal_word,
    output logic [31:0] load_word,
    output logic [31:0] trim_word,
    output logic [4:0] eff_gain,
    output rxs_pkg::rxs_det_bw_e det_bw,
    output logic cal_busy,
    output logic [7:0] i_dac,
    output logic [7:0] q_dac
);
    // ************************************************
    // input synchronisers
    // ************************************************
    localparam int SYN_W = 23;
    localparam int S_CLK = 0;
    localparam int S_DAT = 1;
    localparam int S_STB = 2;
    localparam int S_OSC = 3;
    localparam int S_PIN = 4;
    localparam int S_IRES = 7;
    localparam int S_QRES = 15;

    logic [SYN_W-1:0] syn_meta;
    logic [SYN_W-1:0] syn;
    logic [SYN_W-1:0] syn_prev;
    logic sclk_rise;
    logic strobe_rise;
    logic osc_rise;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            syn_meta <= '0;
            syn <= '0;
            syn_prev <= '0;
        end else begin
            syn_meta <= {cal_q_result, cal_i_result, gain_pins, osc_level,
                link.load_strobe, link.sdata, link.sclk};
            syn <= syn_meta;
            syn_prev <= syn;
        end
    end

    assign sclk_rise = syn[S_CLK] & ~syn_prev[S_CLK]; // see RULE_02
    assign strobe_rise = syn[S_STB] & ~syn_prev[S_STB]; // see RULE_03
    assign osc_rise = syn[S_OSC] & ~syn_prev[S_OSC];

    // ************************************************
    // shift register and load decode
    // ************************************************
    logic [31:0] sr;
    logic hit;
    logic [2:0] sel;
    logic wr_ctrl;
    logic wr_cal;
    logic wr_load;
    logic wr_trim;
    logic rb_cmd;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sr <= '0;
        end else if (sclk_rise) begin
            sr <= {syn[S_DAT], sr[31:1]}; // see RULE_01, see RULE_02
        end
    end

    assign sel = sr[rxs_pkg::SEL_LSB +: rxs_pkg::SEL_W]; // see RULE_04
    // see RULE_04, see RULE_24
    assign hit = strobe_rise && (sr[rxs_pkg::BANK_LSB +: rxs_pkg::BANK_W] == rxs_pkg::BANK_SEL);
    assign wr_ctrl = hit && (sel == rxs_pkg::REG_CTRL); // see RULE_03
    assign wr_cal = hit && (sel == rxs_pkg::REG_CAL);
    assign wr_load = hit && (sel == rxs_pkg::REG_LOAD);
    assign wr_trim = hit && (sel == rxs_pkg::REG_TRIM);
    assign rb_cmd = hit && (sel == rxs_pkg::REG_STATUS); // see RULE_05

    // ************************************************
    // register bank
    // ************************************************
    logic cal_done;

    // reset word sets buffer and cal logic off, mixer and filter on, gain 15, corner 128, attenuator off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_word <= rxs_pkg::CTRL_RST; // see RULE_08, see RULE_09, see RULE_10, see RULE_14
        end else if (wr_ctrl) begin
            ctrl_word <= sr;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_word <= rxs_pkg::CAL_RST; // see RULE_16, see RULE_17, see RULE_18, see RULE_20
        end else if (wr_cal) begin
            cal_word <= sr; // see RULE_21
        end else if (cal_done) begin
            // a fresh write wins over the self-clear
            cal_word[rxs_pkg::K_START] <= 1'b0; // see RULE_15
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_word <= rxs_pkg::LOAD_RST; // see RULE_22, see RULE_23
        end else if (wr_load) begin
            load_word <= sr;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trim_word <= rxs_pkg::TRIM_RST;
        end else if (wr_trim) begin
            trim_word <= sr;
        end
    end

    // ************************************************
    // gain and detector decode
    // ************************************************
    logic [4:0] gain_sat;
    logic [4:0] gain_cut;

    always_comb begin
        gain_sat = ctrl_word[rxs_pkg::C_GAIN_LSB +: rxs_pkg::GAIN_W];
        if (gain_sat > rxs_pkg::GAIN_MAX) begin
            gain_sat = rxs_pkg::GAIN_MAX; // see RULE_09
        end
        gain_cut = '0;
        if (ctrl_word[rxs_pkg::C_FAST_EN]) begin
            gain_cut = {2'h0, syn[S_PIN +: 3]} << ctrl_word[rxs_pkg::C_FAST_X2]; // see RULE_12
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eff_gain <= '0;
            det_bw <= rxs_pkg::DET_10MHZ;
        end else begin
            // gain rails at zero rather than wrapping
            eff_gain <= (gain_sat > gain_cut) ? gain_sat - gain_cut : 5'h0;
            if (!ctrl_word[rxs_pkg::C_DET_R]) begin
                det_bw <= rxs_pkg::DET_10MHZ; // see RULE_11
            end else if (!ctrl_word[rxs_pkg::C_DET_C]) begin
                det_bw <= rxs_pkg::DET_10KHZ;
            end else begin
                det_bw <= rxs_pkg::DET_1KHZ;
            end
        end
    end

    // ************************************************
    // calibration engine
    // ************************************************
    logic [14:0] pre;
    logic [7:0] step;
    logic [14:0] ratio;
    logic cal_tick;
    logic pre_end;

    assign ratio = rxs_pkg::CAL_RATIO[cal_word[rxs_pkg::K_DIV_LSB +: 3]]; // see RULE_19
    // see RULE_20
    assign cal_tick = cal_word[rxs_pkg::K_CLKSEL] ? osc_rise : sclk_rise;
    assign pre_end = (pre == ratio - 15'h1);
    assign cal_done = cal_busy && cal_tick && pre_end && (step == 8'(CAL_STEPS - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_busy <= 1'b0;
            pre <= '0;
            step <= '0;
        end else if (wr_cal && sr[rxs_pkg::K_START]) begin
            cal_busy <= 1'b1; // see RULE_15
            pre <= '0;
            step <= '0;
        end else if (cal_busy && cal_tick) begin
            if (pre_end) begin
                pre <= '0;
                step <= step + 8'h1;
                if (cal_done) begin
                    cal_busy <= 1'b0;
                end
            end else begin
                pre <= pre + 15'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            i_dac <= rxs_pkg::DAC_RST;
            q_dac <= rxs_pkg::DAC_RST;
        end else if (cal_done) begin
            i_dac <= syn[S_IRES +: rxs_pkg::DAC_W];
            q_dac <= syn[S_QRES +: rxs_pkg::DAC_W];
        end else if (!cal_word[rxs_pkg::K_AUTO] && !cal_busy) begin
            i_dac <= cal_word[rxs_pkg::K_IDAC_LSB +: rxs_pkg::DAC_W]; // see RULE_16, see RULE_18
            q_dac <= cal_word[rxs_pkg::K_QDAC_LSB +: rxs_pkg::DAC_W];
        end
    end

    // ************************************************
    // readback
    // ************************************************
    logic [31:0] rb_word;
    logic [31:0] rb_sr;
    logic [5:0] rb_cnt;
    logic rb_active;
    logic rb_bit;
    logic rb_pin;

    always_comb begin
        case (sr[rxs_pkg::RB_SEL_LSB +: 3])
            rxs_pkg::REG_STATUS: rb_word = {i_dac, q_dac, 9'h0, ID_CODE,
                rxs_pkg::BANK_SEL, rxs_pkg::REG_STATUS}; // see RULE_05
            rxs_pkg::REG_CTRL: rb_word = ctrl_word;
            rxs_pkg::REG_CAL: rb_word = cal_word;
            rxs_pkg::REG_LOAD: rb_word = load_word;
            rxs_pkg::REG_TRIM: rb_word = trim_word;
            default: rb_word = '0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rb_active <= 1'b0;
            rb_cnt <= '0;
            rb_sr <= '0;
            rb_bit <= 1'b0;
        end else if (rb_cmd) begin
            rb_active <= 1'b1;
            rb_cnt <= '0;
            rb_sr <= rb_word;
        end else if (rb_active && sclk_rise) begin
            rb_cnt <= rb_cnt + 6'h1; // see RULE_07
            if (rb_cnt != 6'h0) begin
                rb_bit <= rb_sr[0]; // see RULE_06
                rb_sr <= {1'b0, rb_sr[31:1]};
                if (rb_cnt == rb_bits_last()) begin
                    rb_active <= 1'b0;
                end
            end
        end
    end

    function automatic logic [5:0] rb_bits_last();
        return rxs_pkg::RB_BITS;
    endfunction

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rb_pin <= 1'b0;
        end else begin
            rb_pin <= ctrl_word[rxs_pkg::C_OSC_TEST] ? syn[S_OSC] : rb_bit; // see RULE_13
        end
    end

    assign link.readback = rb_pin;
endmodule // rxs_dev

// >>> hdl/rxs_host.sv
// Purpose: host controller driving the three-wire serial port
// Assumes: APB slave, zero wait states
// Notes: serial half period is div pclk cycles

module rxs_host (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    rxs_if.host link
);
    typedef enum logic [3:0] {
        H_IDLE = 4'b0001,
        H_SHIFT = 4'b0010,
        H_STROBE = 4'b0100,
        H_READ = 4'b1000
    } rxs_hstate_e;

    // ************************************************
    // register access
    // ************************************************
    rxs_hstate_e state;
    logic [31:0] tx_word;
    logic [31:0] rx_word;
    logic [7:0] div;
    logic acc_wr;
    logic mapped;
    logic go_wr;
    logic go_rd;

    function automatic logic is_mapped(input logic [7:0] a);
        return (a == rxs_pkg::A_TX) || (a == rxs_pkg::A_CMD) || (a == rxs_pkg::A_STAT)
            || (a == rxs_pkg::A_RX) || (a == rxs_pkg::A_DIV);
    endfunction

    assign mapped = is_mapped(paddr);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign acc_wr = psel && penable && pwrite && mapped;
    // commands are dropped while a transfer runs
    assign go_wr = acc_wr && (paddr == rxs_pkg::A_CMD) && (state == H_IDLE)
        && pwdata[rxs_pkg::CMD_WRITE];
    assign go_rd = acc_wr && (paddr == rxs_pkg::A_CMD) && (state == H_IDLE)
        && pwdata[rxs_pkg::CMD_READ];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_word <= '0;
            div <= rxs_pkg::DIV_RST;
        end else if (acc_wr) begin
            if (paddr == rxs_pkg::A_TX) begin
                tx_word <= pwdata;
            end
            if (paddr == rxs_pkg::A_DIV) begin
                div <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (psel && !penable) begin
            case (paddr)
                rxs_pkg::A_TX: prdata <= tx_word;
                rxs_pkg::A_STAT: prdata <= {31'h0, state != H_IDLE};
                rxs_pkg::A_RX: prdata <= rx_word;
                rxs_pkg::A_DIV: prdata <= {24'h0, div};
                default: prdata <= '0;
            endcase
        end
    end

    // ************************************************
    // serial engine
    // ************************************************
    logic rb_meta;
    logic rb_sync;
    logic [7:0] cnt;
    logic half_end;
    logic [31:0] sr;
    logic [5:0] bitn;
    logic is_read;
    logic sclk;
    logic sdata;
    logic strobe;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rb_meta <= 1'b0;
            rb_sync <= 1'b0;
        end else begin
            rb_meta <= link.readback;
            rb_sync <= rb_meta;
        end
    end

    // div of zero behaves as one
    assign half_end = ({1'b0, cnt} + 9'h1) >= {1'b0, div};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= H_IDLE;
            cnt <= '0;
            sr <= '0;
            bitn <= '0;
            is_read <= 1'b0;
            sclk <= 1'b0;
            sdata <= 1'b0;
            strobe <= 1'b0;
            rx_word <= '0;
        end else begin
            cnt <= half_end ? 8'h0 : cnt + 8'h1;
            case (state)
                H_IDLE: begin
                    cnt <= '0;
                    if (go_wr || go_rd) begin
                        state <= H_SHIFT;
                        sr <= tx_word;
                        sdata <= tx_word[0]; // see RULE_02
                        bitn <= '0;
                        is_read <= go_rd;
                    end
                end
                H_SHIFT: begin
                    if (half_end) begin
                        sclk <= !sclk;
                        if (sclk) begin
                            if (bitn == rxs_pkg::RB_BITS - 6'h1) begin
                                state <= H_STROBE;
                            end else begin
                                bitn <= bitn + 6'h1;
                                sr <= {1'b0, sr[31:1]};
                                sdata <= sr[1];
                            end
                        end
                    end
                end
                H_STROBE: begin
                    if (half_end) begin
                        strobe <= !strobe; // see RULE_03
                        bitn <= '0;
                        if (strobe) begin
                            state <= is_read ? H_READ : H_IDLE; // see RULE_05
                        end
                    end
                end
                H_READ: begin
                    if (half_end) begin
                        sclk <= !sclk;
                        if (sclk) begin
                            if (bitn != 6'h0) begin
                                rx_word <= {rb_sync, rx_word[31:1]}; // see RULE_06
                            end
                            if (bitn == rxs_pkg::RB_BITS) begin
                                state <= H_IDLE; // see RULE_07
                            end else begin
                                bitn <= bitn + 6'h1;
                            end
                        end
                    end
                end
                default: state <= H_IDLE;
            endcase
        end
    end

    assign link.sclk = sclk;
    assign link.sdata = sdata;
    assign link.load_strobe = strobe;
endmodule // rxs_host

// >>> test/rxs_monitor.sv
// Purpose: wire-level checks between host and device ends
// Assumes: host half period left at its reset value of 8 pclk
// Notes: takes the link signals as plain inputs, no bind
module rxs_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sclk,
    input wire logic sdata,
    input wire logic load_strobe,
    input wire logic readback
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sclk_d;
    logic strobe_d;
    logic [5:0] hist;
    logic [6:0] pulses;
    logic [4:0] low_run;
    // a long low run marks a frame gap, so stray readback pulses never leak into a count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_d <= 1'b0;
            strobe_d <= 1'b0;
            hist <= '0;
            pulses <= '0;
            low_run <= '0;
        end else begin
            sclk_d <= sclk;
            strobe_d <= load_strobe;
            hist <= {hist[4:0], sclk & !sclk_d};
            low_run <= sclk ? 5'h00 : (low_run == 5'h1F ? low_run : low_run + 5'h01);
            // a rise counts even when it ends a long gap; only a strobe fall in the same cycle clears instead
            if ((strobe_d && !load_strobe) || (low_run > 5'h14 && !sclk)) begin
                pulses <= '0;
            end else if (sclk && !sclk_d) begin
                pulses <= pulses + 7'h01;
            end
        end
    end
    property p_strobe_low;
        @(posedge pclk) disable iff (!presetn) load_strobe |-> !sclk;
    endproperty
    a_strobe_low: assert property (p_strobe_low) else $error("strobe with sclk high");
    property p_strobe_width;
        @(posedge pclk) disable iff (!presetn)
            $rose(load_strobe) |-> load_strobe [*8] ##1 !load_strobe;
    endproperty
    a_strobe_width: assert property (p_strobe_width) else $error("strobe width");
    property p_data_hold;
        @(posedge pclk) disable iff (!presetn) (sclk && sclk_d) |-> $stable(sdata);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("sdata moved");
    property p_high_half;
        @(posedge pclk) disable iff (!presetn) $rose(sclk) |-> sclk [*8] ##1 !sclk;
    endproperty
    a_high_half: assert property (p_high_half) else $error("sclk high half");
    property p_low_half;
        @(posedge pclk) disable iff (!presetn) $fell(sclk) |-> !sclk [*8];
    endproperty
    a_low_half: assert property (p_low_half) else $error("sclk low half");
    property p_word_len;
        @(posedge pclk) disable iff (!presetn) $rose(load_strobe) |-> pulses == 7'h20;
    endproperty
    a_word_len: assert property (p_word_len) else $error("pulse count");
    property p_rb_launch;
        @(posedge pclk) disable iff (!presetn) $changed(readback) |-> hist[5:1] != 5'h00;
    endproperty
    a_rb_launch: assert property (p_rb_launch) else $error("readback moved");
    property p_rb_sample;
        @(posedge pclk) disable iff (!presetn) $fell(sclk) |-> $stable(readback);
    endproperty
    a_rb_sample: assert property (p_rb_sample) else $error("readback at fall");
endmodule // rxs_monitor

// >>> test/rxs_tb.sv
// Purpose: host and device joined, driven over apb
// Assumes: CAL_STEPS 2, ratio code 1 in calibration tests
// Notes: expectations come from register layouts
module rxs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, osc_level = 0;
    logic pslverr, pready, cal_busy, e;
    logic [7:0] paddr = 0, ci = 8'h3C, cq = 8'hC3, i_dac, q_dac;
    logic [2:0] gain_pins = 0;
    logic [31:0] pwdata = 0, prdata, ctrl_word, cal_word, load_word, trim_word, q;
    logic [4:0] eff_gain;
    rxs_pkg::rxs_det_bw_e det_bw;
    int miscompares = 0, comparisons = 0, cycles = 0;
    rxs_if link_if();
    rxs_host rxs_host_inst (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .link(link_if));
    rxs_dev #(.CAL_STEPS(2)) rxs_dev_inst (.pclk, .presetn, .link(link_if), .gain_pins,
        .osc_level, .cal_i_result(ci), .cal_q_result(cq), .ctrl_word, .cal_word, .load_word,
        .trim_word, .eff_gain, .det_bw, .cal_busy, .i_dac, .q_dac);
    rxs_monitor rxs_monitor_inst (.pclk, .presetn, .sclk(link_if.sclk),
        .sdata(link_if.sdata), .load_strobe(link_if.load_strobe), .readback(link_if.readback));
    always #4 pclk = ~pclk;
    // slow stand-in oscillator, also the calibration tick source
    always @(posedge pclk) begin
        cycles++;
        if (cycles % 4 == 0) osc_level <= ~osc_level;
        if (cycles == 60000) begin
            miscompares++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        comparisons++;
        if (g !== x) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", n, x, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask
    // idle gap keeps frames apart for the monitor's pulse counter
    task automatic send(input logic [31:0] w, input logic rd);
        apb(1, rxs_pkg::A_TX, w);
        apb(1, rxs_pkg::A_CMD, rd ? 32'h2 : 32'h1);
        q = 1;
        while (q[0] !== 1'b0) apb(0, rxs_pkg::A_STAT, 0);
        repeat (30) @(posedge pclk);
    endtask
    task automatic t_reset();
        chk("ctrl", 32'h0100FC89, ctrl_word);
        chk("cal", 32'h71E0200A, cal_word);
        chk("load", 32'h4000000B, load_word);
        chk("trim", 32'h0000AAAD, trim_word);
        chk("gain", 32'd15, eff_gain);
        chk("idac", 32'h80, i_dac);
        chk("qdac", 32'h80, q_dac);
    endtask
    task automatic t_ctrl();
        logic [1:0] bw [4] = '{2'h0, 2'h1, 2'h0, 2'h3};
        gain_pins <= 3'h5;
        for (int d = 0; d < 4; d++) begin
            send(32'h99FF85A9 | (d << 25), 0);
            chk("ctrl", 32'h99FF85A9 | (d << 25), ctrl_word);
            chk("det", bw[d], det_bw);
            chk("gain", 32'd14, eff_gain);
        end
        gain_pins <= 3'h7;
        send(32'h18003009, 0);
        chk("gain", 32'd0, eff_gain);
        send(32'h08000008, 1);
        apb(0, rxs_pkg::A_RX, 0);
        chk("rx", 32'h18003009, q);
        apb(0, rxs_pkg::A_TX, 0);
        chk("tx", 32'h08000008, q);
        apb(0, rxs_pkg::A_DIV, 0);
        chk("div", 32'h8, q);
    endtask
    task automatic t_ignore();
        send(32'h0000000C, 0);
        send(32'hFFFFFFF1, 0);
        chk("ctrl", 32'h18003009, ctrl_word);
        chk("load", 32'h4000000B, load_word);
        send(32'h3FFFFFEB, 0);
        chk("load", 32'h3FFFFFEB, load_word);
        send(32'h1234560D, 0);
        chk("trim", 32'h1234560D, trim_word);
    endtask
    task automatic t_cal();
        send(32'h1300002A, 0);
        chk("busy", 32'h1, cal_busy);
        for (int n = 0; n < 2000 && cal_busy !== 1'b0; n++) @(posedge pclk);
        chk("busy", 32'h0, cal_busy);
        chk("cal", 32'h1300000A, cal_word);
        chk("idac", 32'h3C, i_dac);
        chk("qdac", 32'hC3, q_dac);
        send(32'h00000008, 1);
        apb(0, rxs_pkg::A_RX, 0);
        chk("rx", 32'h3CC30048, q);
        send(32'h0008844A, 0);
        chk("idac", 32'h11, i_dac);
        chk("qdac", 32'h22, q_dac);
        apb(0, 8'h14, 0);
        chk("err", 32'h1, e);
        chk("err_data", 32'h0, q);
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1;
        repeat (2) @(posedge pclk);
        t_reset();
        t_ctrl();
        t_ignore();
        t_cal();
        give_verdict();
    end
endmodule // rxs_tb
